// ---- design/fip_pkg.sv ----
// constants and types for the flash page programming host
package fip_pkg;
  // device special function register addresses
  localparam logic [7:0] SFR_CTRL0 = 8'h43;
  localparam logic [7:0] SFR_CTRL2 = 8'h45;
  localparam logic [7:0] SFR_ADDR_LO = 8'h46;
  localparam logic [7:0] SFR_ADDR_HI = 8'h47;
  localparam logic [7:0] SFR_W0_LO = 8'h48;
  localparam logic [7:0] SFR_W0_HI = 8'h49;
  localparam logic [7:0] SFR_W1_LO = 8'h4a;
  localparam logic [7:0] SFR_W1_HI = 8'h4b;
  localparam logic [7:0] SFR_W2_LO = 8'h4c;
  localparam logic [7:0] SFR_W2_HI = 8'h4d;
  localparam logic [7:0] SFR_W3_LO = 8'h4e;
  localparam logic [7:0] SFR_W3_HI = 8'h4f;
  // flash_control_0 fields
  localparam int EWEN_BIT = 7;
  localparam int OPSEL_LSB = 4;
  localparam int ARM_BIT = 3;
  localparam int TRIG_BIT = 2;
  localparam int RDEN_BIT = 1;
  localparam int RDTRIG_BIT = 0;
  // flash_control_2 fields
  localparam int CLR_BIT = 0;
  localparam int TSEL_BIT = 1;
  localparam logic [7:0] ARM_MASK = 8'h01 << ARM_BIT;
  localparam logic [7:0] TRIG_MASK = 8'h01 << TRIG_BIT;
  localparam logic [7:0] RDEN_MASK = 8'h01 << RDEN_BIT;
  localparam logic [7:0] RDTRIG_MASK = 8'h01 << RDTRIG_BIT;
  localparam logic [7:0] CLR_MASK = 8'h01 << CLR_BIT;
  // operation select codes
  localparam logic [2:0] OPSEL_WRITE = 3'h0;
  localparam logic [2:0] OPSEL_ERASE = 3'h1;
  localparam logic [2:0] OPSEL_READ = 3'h3;
  localparam logic [2:0] OPSEL_UNLOCK = 3'h6;
  // unlock pattern
  localparam logic [7:0] UNLOCK_W1_LO = 8'h00;
  localparam logic [7:0] UNLOCK_W2_LO = 8'h0d;
  localparam logic [7:0] UNLOCK_W3_LO = 8'hc3;
  localparam logic [7:0] UNLOCK_W1_HI = 8'h04;
  localparam logic [7:0] UNLOCK_W2_HI = 8'h09;
  localparam logic [7:0] UNLOCK_W3_HI = 8'h40;
  localparam logic [6:0] PAGE_WORDS = 7'h40;
  localparam logic [15:0] BLANK_WORD = 16'h0000;
  // software register map (byte offsets)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_COUNT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_RDATA = 12'h010;
  localparam logic [3:0] OFS_BUF_PAGE = 4'h1;
  localparam int CTRL_TSEL_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EN_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_BLANK_BIT = 3;
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_UNLOCK = 3'h1;
  localparam logic [2:0] CMD_ERASE = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h4;
  localparam logic [2:0] CMD_DISABLE = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_READ} fip_state_e;
  typedef enum logic [2:0] {OP_WR, OP_POLL, OP_CAP, OP_LOOP, OP_END} fip_op_e;
  typedef struct packed {
    fip_op_e kind;
    logic [7:0] addr;
    logic [7:0] data;
  } fip_op_s;
endpackage

// ---- design/fip_host.sv ----
// host sequencer driving the flash programming registers, commanded over axi4-lite
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module fip_host (
  input wire logic aclk, // system clock, 10 mhz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state but the check helpers, which still clear in ST_IDLE, when low
  input wire logic [11:0] awaddr, // axi write address
  input wire logic awvalid, // axi write address valid
  output logic awready, // axi write address ready
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi write strobes
  input wire logic wvalid, // axi write data valid
  output logic wready, // axi write data ready
  output logic [1:0] bresp, // axi write response
  output logic bvalid, // axi write response valid
  input wire logic bready, // axi write response ready
  input wire logic [11:0] araddr, // axi read address
  input wire logic arvalid, // axi read address valid
  output logic arready, // axi read address ready
  output logic [31:0] rdata, // axi read data
  output logic [1:0] rresp, // axi read response
  output logic rvalid, // axi read valid
  input wire logic rready, // axi read ready
  output logic [7:0] sfr_addr, // device register address
  output logic [7:0] sfr_wdata, // device register write data
  output logic sfr_wr, // device register write strobe
  output logic sfr_rd, // device register read strobe
  input wire logic [7:0] sfr_rdata, // device read data, valid while sfr_rd is high
  input wire logic dev_stall // device has the processor stalled
);
  import fip_pkg::*;

  fip_state_e state;
  logic [2:0] cmd;
  logic [3:0] step;
  logic [5:0] widx;
  logic [5:0] wlast;
  logic tsel;
  logic flag_en;
  logic err;
  logic blank;
  logic [15:0] rword;
  logic [15:0] faddr;
  logic [6:0] count;
  logic [15:0] wbuf [64];

  // flash_control_0 image
  function automatic logic [7:0] ctrl0(input logic [2:0] mode, input logic en, input logic [7:0] extra);
    logic [7:0] v;
    v = 8'h00;
    v[EWEN_BIT] = en;
    v[OPSEL_LSB +: 3] = mode;
    return v | extra;
  endfunction

  function automatic fip_op_s mk(input fip_op_e k, input logic [7:0] a, input logic [7:0] d);
    fip_op_s o;
    o.kind = k;
    o.addr = a;
    o.data = d;
    return o;
  endfunction

  // byte-lane merge of a software write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return v;
  endfunction

  // step table: each command is a short program of device accesses
  function automatic fip_op_s op_of(input logic [2:0] c, input logic [3:0] s, input logic en,
                                    input logic t, input logic [15:0] a, input logic [15:0] w);
    logic [7:0] c2;
    fip_op_s o;
    c2 = CLR_MASK;
    c2[TSEL_BIT] = t;
    o = mk(OP_END, 8'h00, 8'h00);
    case (c)
      CMD_UNLOCK: begin
        case (s)
          4'h0: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_UNLOCK, en, 8'h00));
          4'h1: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_UNLOCK, en, ARM_MASK));
          4'h2: o = mk(OP_WR, SFR_W1_LO, UNLOCK_W1_LO);
          4'h3: o = mk(OP_WR, SFR_W2_LO, UNLOCK_W2_LO);
          4'h4: o = mk(OP_WR, SFR_W3_LO, UNLOCK_W3_LO);
          4'h5: o = mk(OP_WR, SFR_W1_HI, UNLOCK_W1_HI);
          4'h6: o = mk(OP_WR, SFR_W2_HI, UNLOCK_W2_HI);
          4'h7: o = mk(OP_WR, SFR_W3_HI, UNLOCK_W3_HI);
          4'h8: o = mk(OP_POLL, SFR_CTRL0, ARM_MASK);
          4'h9: o = mk(OP_CAP, SFR_CTRL0, 8'h00);
          default: o = mk(OP_END, 8'h00, 8'h00);
        endcase
      end
      CMD_ERASE: begin
        case (s)
          4'h0: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_ERASE, en, 8'h00));
          4'h1: o = mk(OP_WR, SFR_CTRL2, c2);
          4'h2: o = mk(OP_WR, SFR_ADDR_LO, a[7:0]);
          4'h3: o = mk(OP_WR, SFR_ADDR_HI, a[15:8]);
          4'h4: o = mk(OP_WR, SFR_W0_HI, 8'h00); // tag cnt_eff addresses, one per loop pass
          4'h5: o = mk(OP_LOOP, 8'h00, 8'h04);
          4'h6: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_ERASE, en, TRIG_MASK));
          4'h7: o = mk(OP_POLL, SFR_CTRL0, TRIG_MASK);
          default: o = mk(OP_END, 8'h00, 8'h00);
        endcase
      end
      CMD_WRITE: begin
        case (s)
          4'h0: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_WRITE, en, 8'h00));
          4'h1: o = mk(OP_WR, SFR_CTRL2, c2);
          4'h2: o = mk(OP_WR, SFR_ADDR_LO, a[7:0]);
          4'h3: o = mk(OP_WR, SFR_ADDR_HI, a[15:8]);
          4'h4: o = mk(OP_WR, SFR_W0_LO, w[7:0]);
          4'h5: o = mk(OP_WR, SFR_W0_HI, w[15:8]);
          4'h6: o = mk(OP_LOOP, 8'h00, 8'h04);
          4'h7: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_WRITE, en, TRIG_MASK));
          4'h8: o = mk(OP_POLL, SFR_CTRL0, TRIG_MASK);
          default: o = mk(OP_END, 8'h00, 8'h00);
        endcase
      end
      CMD_READ: begin
        case (s)
          4'h0: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_READ, en, RDEN_MASK));
          4'h1: o = mk(OP_WR, SFR_ADDR_LO, a[7:0]);
          4'h2: o = mk(OP_WR, SFR_ADDR_HI, a[15:8]);
          4'h3: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_READ, en, RDEN_MASK | RDTRIG_MASK));
          4'h4: o = mk(OP_POLL, SFR_CTRL0, RDTRIG_MASK);
          4'h5: o = mk(OP_CAP, SFR_W0_LO, 8'h00);
          4'h6: o = mk(OP_CAP, SFR_W0_HI, 8'h00);
          default: o = mk(OP_END, 8'h00, 8'h00);
        endcase
      end
      CMD_DISABLE: begin
        case (s)
          4'h0: o = mk(OP_WR, SFR_CTRL0, ctrl0(OPSEL_WRITE, 1'b0, 8'h00));
          4'h1: o = mk(OP_CAP, SFR_CTRL0, 8'h00);
          default: o = mk(OP_END, 8'h00, 8'h00);
        endcase
      end
      default: o = mk(OP_END, 8'h00, 8'h00);
    endcase
    return o;
  endfunction

  // current access and its outcome
  fip_op_s op;
  wire logic issue;
  wire logic poll_done;
  assign op = op_of(cmd, step, flag_en, tsel, faddr, wbuf[widx]);
  // accesses go out at most one per cycle; reads, loop steps and dev_stall leave idle cycles between them
  assign issue = ce && (state == ST_RUN) && !dev_stall;
  assign poll_done = (sfr_rdata & op.data) == 8'h00;

  // software write decode
  wire logic wr_go;
  wire logic w_ctrl;
  wire logic w_addr;
  wire logic w_count;
  wire logic w_buf;
  wire logic w_known;
  wire logic [2:0] new_cmd;
  wire logic refuse;
  wire logic [31:0] wmerged;
  assign wr_go = ce && awvalid && wvalid && !bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign w_ctrl = awaddr == OFS_CTRL;
  assign w_addr = awaddr == OFS_ADDR;
  assign w_count = awaddr == OFS_COUNT;
  assign w_buf = (awaddr[11:8] == OFS_BUF_PAGE) && (awaddr[1:0] == 2'h0);
  assign w_known = w_ctrl || w_addr || w_count || w_buf || awaddr == OFS_STATUS || awaddr == OFS_RDATA;
  assign new_cmd = wdata[2:0];
  // erase and program need the enabled flag seen high
  assign refuse = (state != ST_IDLE) || (new_cmd > CMD_DISABLE)
               || ((new_cmd == CMD_ERASE || new_cmd == CMD_WRITE) && !flag_en);
  assign wmerged = merge({16'h0000, wbuf[awaddr[7:2]]}, wdata, wstrb);

  // clamp the word count to one page, zero meaning one
  wire logic [6:0] cnt_eff;
  assign cnt_eff = (count == 7'h00) ? 7'h01 : ((count > PAGE_WORDS) ? PAGE_WORDS : count);

  // software read decode
  wire logic ar_go;
  wire logic r_buf;
  logic [31:0] rd_val;
  assign ar_go = ce && arvalid && !rvalid;
  assign arready = ar_go;
  assign r_buf = (araddr[11:8] == OFS_BUF_PAGE) && (araddr[1:0] == 2'h0);
  always_comb begin
    rd_val = 32'h0000_0000;
    if (araddr == OFS_CTRL) begin
      rd_val = {23'h000000, tsel, 5'h00, cmd};
    end else if (araddr == OFS_ADDR) begin
      rd_val = {16'h0000, faddr};
    end else if (araddr == OFS_COUNT) begin
      rd_val = {25'h0000000, count};
    end else if (araddr == OFS_STATUS) begin
      rd_val = {28'h0000000, blank, err, flag_en, state != ST_IDLE};
    end else if (araddr == OFS_RDATA) begin
      rd_val = {16'h0000, rword};
    end else if (r_buf) begin
      rd_val = {16'h0000, wbuf[araddr[7:2]]};
    end
  end
  wire logic r_known;
  assign r_known = r_buf || araddr == OFS_CTRL || araddr == OFS_ADDR || araddr == OFS_COUNT
                || araddr == OFS_STATUS || araddr == OFS_RDATA;

  // axi response channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= w_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (ar_go) begin
        rvalid <= 1'b1;
        rresp <= r_known ? RESP_OKAY : RESP_SLVERR;
        rdata <= rd_val;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // word buffer, frozen while a command runs so the page image stays whole
  always_ff @(posedge aclk) begin
    if (ce && wr_go && w_buf && state == ST_IDLE) begin
      wbuf[awaddr[7:2]] <= wmerged[15:0];
    end
  end

  // merged images of the setup registers; a function result cannot be part-selected
  wire logic [31:0] addr_merged;
  wire logic [31:0] count_merged;
  assign addr_merged = merge({16'h0000, faddr}, wdata, wstrb);
  assign count_merged = merge({25'h0000000, count}, wdata, wstrb);

  // setup registers, ignored while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      faddr <= 16'h0000;
      count <= PAGE_WORDS;
    end else if (ce && wr_go && state == ST_IDLE) begin
      if (w_addr) begin
        faddr <= addr_merged[15:0];
      end
      if (w_count) begin
        count <= count_merged[6:0];
      end
    end
  end

  // sequencer: one device access per cycle, reads take a second cycle to sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cmd <= CMD_NONE;
      step <= 4'h0;
      widx <= 6'h00;
      wlast <= 6'h00;
      tsel <= 1'b0;
      err <= 1'b0;
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      sfr_addr <= 8'h00;
      sfr_wdata <= 8'h00;
    end else if (ce) begin
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      if (state == ST_IDLE && wr_go && w_ctrl && new_cmd != CMD_NONE) begin
        err <= refuse;
        if (!refuse) begin
          state <= ST_RUN;
          cmd <= new_cmd;
          step <= 4'h0;
          widx <= 6'h00;
          wlast <= 6'(cnt_eff - 7'h01);
          tsel <= wdata[CTRL_TSEL_BIT];
        end
      end else if (state != ST_IDLE && wr_go && w_ctrl && new_cmd != CMD_NONE) begin
        err <= 1'b1;
      end
      if (issue) begin
        unique case (op.kind)
          OP_WR: begin
            sfr_wr <= 1'b1;
            sfr_addr <= op.addr;
            sfr_wdata <= op.data;
            step <= step + 4'h1;
          end
          OP_POLL, OP_CAP: begin
            sfr_rd <= 1'b1;
            sfr_addr <= op.addr;
            state <= ST_READ;
          end
          OP_LOOP: begin
            if (widx == wlast) begin
              step <= step + 4'h1;
            end else begin
              widx <= widx + 6'h01;
              step <= op.data[3:0];
            end
          end
          OP_END: state <= ST_IDLE;
        endcase
      end else if (state == ST_READ) begin
        state <= ST_RUN;
        if (op.kind != OP_POLL || poll_done) begin
          step <= step + 4'h1;
        end
      end
    end
  end

  // captured device state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_en <= 1'b0;
      rword <= 16'h0000;
      blank <= 1'b0;
    end else if (ce && state == ST_READ && op.kind == OP_CAP) begin
      if (op.addr == SFR_CTRL0) begin
        flag_en <= sfr_rdata[EWEN_BIT];
      end else if (op.addr == SFR_W0_LO) begin
        rword[7:0] <= sfr_rdata;
      end else begin
        rword[15:8] <= sfr_rdata;
        blank <= {sfr_rdata, rword[7:0]} == BLANK_WORD;
      end
    end
  end

  // helper state for the checks below
  wire logic trig_wr;
  wire logic prog_trig;
  logic trig_pend;
  logic clr_seen;
  logic lo_loaded;
  logic [6:0] hi_cnt;
  assign trig_wr = sfr_wr && sfr_addr == SFR_CTRL0 && (sfr_wdata & (TRIG_MASK | RDTRIG_MASK)) != 8'h00;
  assign prog_trig = sfr_wr && sfr_addr == SFR_CTRL0 && sfr_wdata[TRIG_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_IDLE) begin
      trig_pend <= 1'b0;
      clr_seen <= 1'b0;
      lo_loaded <= 1'b0;
      hi_cnt <= 7'h00;
    end else if (ce) begin
      if (trig_wr) begin
        trig_pend <= 1'b1;
      end else if (state == ST_READ && op.kind == OP_POLL && poll_done) begin
        trig_pend <= 1'b0;
      end
      if (sfr_wr && sfr_addr == SFR_CTRL2 && sfr_wdata[CLR_BIT]) begin
        clr_seen <= 1'b1;
      end
      if (sfr_wr && sfr_addr == SFR_W0_LO) begin
        lo_loaded <= 1'b1;
      end else if (sfr_wr && sfr_addr == SFR_W0_HI) begin
        lo_loaded <= 1'b0;
        hi_cnt <= hi_cnt + 7'h01;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_arm;
    sfr_wr && sfr_addr == SFR_CTRL0 && sfr_wdata[ARM_BIT] && !dev_stall && ce;
  endsequence
  sequence s_first_pattern;
    sfr_wr && sfr_addr == SFR_W1_LO && sfr_wdata == UNLOCK_W1_LO;
  endsequence

  a_unlock_start: assert property (s_arm |=> s_first_pattern)
    else $error("unlock pattern did not follow the arm write");
  a_unlock_bytes: assert property (sfr_wr && sfr_addr == SFR_W3_LO && cmd == CMD_UNLOCK
    |-> sfr_wdata == UNLOCK_W3_LO && $past(sfr_addr) == SFR_W2_LO)
    else $error("unlock pattern byte or order wrong");
  a_low_first: assert property (sfr_wr && sfr_addr == SFR_W0_HI && cmd == CMD_WRITE |-> lo_loaded)
    else $error("high byte written before low byte");
  a_erase_mode: assert property (prog_trig && cmd == CMD_ERASE
    |-> sfr_wdata[OPSEL_LSB +: 3] == OPSEL_ERASE && clr_seen && hi_cnt != 7'h00)
    else $error("erase trigger without erase select, clear or tag");
  a_prog_mode: assert property (prog_trig && cmd == CMD_WRITE |-> sfr_wdata[OPSEL_LSB +: 3] == OPSEL_WRITE)
    else $error("program trigger without write select");
  a_hold_trig: assert property (trig_pend |-> !sfr_wr)
    else $error("device written while a trigger is high");
  a_enabled_first: assert property (prog_trig |-> flag_en)
    else $error("erase or program requested while not enabled");
  a_retry_clear: assert property (prog_trig && cmd == CMD_WRITE |-> clr_seen && !lo_loaded)
    else $error("program without buffer clear or with half a word");
  a_page_limit: assert property (prog_trig |-> hi_cnt <= PAGE_WORDS)
    else $error("more than one page loaded");
  a_disable_clear: assert property (sfr_wr && sfr_addr == SFR_CTRL0 && cmd == CMD_DISABLE
    |-> !sfr_wdata[EWEN_BIT])
    else $error("disable left the enabled flag set");
  a_read_setup: assert property (sfr_wr && sfr_addr == SFR_CTRL0 && sfr_wdata[RDTRIG_BIT]
    |-> sfr_wdata[OPSEL_LSB +: 3] == OPSEL_READ && sfr_wdata[RDEN_BIT]
        && $past(sfr_addr) == SFR_ADDR_HI)
    else $error("read trigger without read setup");
endmodule
`default_nettype wire

// ---- tb/fip_dev_model.sv ----
// behavioural flash array with its control registers, as seen over the register link
`timescale 1ns/1ns
`default_nettype none
module fip_dev_model (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] sfr_addr, // register address
  input wire logic [7:0] sfr_wdata, // register write data
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  output logic [7:0] sfr_rdata, // read data
  output logic dev_stall // processor held
);
  import fip_pkg::*;
  logic [7:0] c0, c2, lo, cnt;
  logic [7:0] pat [10:15];
  logic [15:0] fa, w0;
  logic [15:0] mem [0:255];
  logic [15:0] wb [0:63]; // one page of buffer
  // start conditions of the three timed jobs
  wire [2:0] sel = sfr_wdata[6:4];
  wire arm_go = sfr_wdata[ARM_BIT] && sel == OPSEL_UNLOCK;
  wire trig_go = sfr_wdata[TRIG_BIT] && c0[EWEN_BIT] && (sel == OPSEL_WRITE || sel == OPSEL_ERASE);
  wire rd_go = sfr_wdata[RDTRIG_BIT] && sfr_wdata[RDEN_BIT] && sel == OPSEL_READ;
  wire busy = c0[ARM_BIT] | c0[TRIG_BIT] | c0[RDTRIG_BIT];
  wire good = {pat[10], pat[11], pat[12], pat[13], pat[14], pat[15]} ==
    {UNLOCK_W1_LO, UNLOCK_W1_HI, UNLOCK_W2_LO, UNLOCK_W2_HI, UNLOCK_W3_LO, UNLOCK_W3_HI};
  // read mux; outside a strobe the bus shows the inverse so stale data never passes
  wire [7:0] mux = sfr_addr == SFR_CTRL0 ? c0 : sfr_addr == SFR_W0_LO ? w0[7:0] : sfr_addr == SFR_W0_HI ? w0[15:8] : 8'h00;
  assign sfr_rdata = sfr_rd ? mux : ~mux;
  assign dev_stall = c0[TRIG_BIT] | c0[RDTRIG_BIT];
  // register writes and job completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c0 <= 8'h00;
      c2 <= 8'h00;
      cnt <= 8'h00;
      for (int i = 0; i < 256; i++) mem[i] <= 16'hffff;
    end else begin
      if (cnt != 8'h00) cnt <= cnt - 8'h01;
      if (busy && cnt == 8'h01) begin
        c0[3:0] <= {1'b0, 1'b0, c0[RDEN_BIT], 1'b0};
        if (c0[ARM_BIT]) c0[EWEN_BIT] <= good;
        if (c0[RDTRIG_BIT]) w0 <= mem[fa[7:0]];
        if (c0[TRIG_BIT]) for (int i = 0; i < 64; i++) begin
          mem[{fa[7:6], 6'(i)}] <= c0[6:4] == OPSEL_ERASE ? BLANK_WORD : mem[{fa[7:6], 6'(i)}] | wb[i];
        end
      end
      // writes are dropped while a trigger runs
      if (sfr_wr && !dev_stall) case (sfr_addr)
        SFR_CTRL0: begin
          c0 <= {c0[EWEN_BIT] & sfr_wdata[EWEN_BIT], sel, arm_go, trig_go, sfr_wdata[RDEN_BIT], rd_go};
          if (arm_go | trig_go | rd_go) cnt <= rd_go ? 8'd3 : arm_go ? 8'd30 : c2[TSEL_BIT] ? 8'd60 : 8'd40;
        end
        SFR_CTRL2: begin
          c2 <= sfr_wdata;
          if (sfr_wdata[CLR_BIT]) for (int i = 0; i < 64; i++) wb[i] <= 16'h0000;
        end
        SFR_ADDR_LO: fa[7:0] <= sfr_wdata;
        SFR_ADDR_HI: fa[15:8] <= sfr_wdata;
        SFR_W0_LO: lo <= sfr_wdata;
        SFR_W0_HI: begin
          wb[fa[5:0]] <= {sfr_wdata, lo};
          if (fa[5:0] != 6'h3f) fa <= fa + 16'h0001;
        end
        default: if (sfr_addr[7:4] == 4'h4 && sfr_addr[3:0] >= 4'ha) pat[sfr_addr[3:0]] <= sfr_wdata;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/fip_host_bench.sv ----
// bench for the flash programming host: axi4-lite command sequences against the device model
`timescale 1ns/1ns
`default_nettype none
module fip_host_bench;
  import fip_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sfr_wr, sfr_rd, dev_stall;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  int bad_count = 0, compares = 0;
  // 10 mhz clock
  always #50 aclk = ~aclk;
  fip_host fip_host_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .dev_stall(dev_stall));
  fip_dev_model fip_dev_model_i (.aclk(aclk), .aresetn(aresetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .dev_stall(dev_stall));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // axi write: both channels offered together, bready held until bvalid
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // command then bounded poll of the busy flag
  task automatic cmd(input logic [31:0] c);
    axw(OFS_CTRL, c);
    repeat (300) begin
      axr(OFS_STATUS);
      if (rd[STAT_BUSY_BIT] === 1'b0) break;
    end
    chk(32'(rd[STAT_BUSY_BIT]), 32'h0);
  endtask
  task automatic rdw(input logic [15:0] a);
    axw(OFS_ADDR, {16'h0000, a});
    cmd({29'h0, CMD_READ});
    axr(OFS_RDATA);
  endtask
  // loads buffer words from word 0 and runs one write command
  task automatic wr(input logic [15:0] a, input logic [15:0] d0, input logic [15:0] d1, input logic [15:0] d2,
      input logic [6:0] n);
    axw(12'h100, {16'h0000, d0});
    axw(12'h104, {16'h0000, d1});
    axw(12'h108, {16'h0000, d2});
    axw(OFS_ADDR, {16'h0000, a});
    axw(OFS_COUNT, {25'h0, n});
    cmd({29'h0, CMD_WRITE});
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_COUNT);
    chk(rd, 32'h40);
    axr(12'h0f0);
    chk(32'(rs), 32'(RESP_SLVERR));
    $display("test 1 done");
    axw(OFS_ADDR, 32'h40);
    chk(32'(rs), 32'(RESP_OKAY));
    cmd({29'h0, CMD_ERASE});
    axr(OFS_STATUS);
    chk(32'(rd[STAT_ERR_BIT]), 32'h1);
    rdw(16'h0045);
    chk(32'(rd[15:0]), 32'h0000ffff);
    $display("test 2 done");
    cmd({29'h0, CMD_UNLOCK});
    axr(OFS_STATUS);
    chk(32'(rd[STAT_EN_BIT]), 32'h1);
    for (int p = 1; p < 3; p++) begin
      axw(OFS_ADDR, 32'(p * 64));
      cmd({23'h0, 1'b1, 5'h0, CMD_ERASE});
      rdw(16'(p * 64 + 5));
      axr(OFS_STATUS);
      chk(32'(rd[STAT_BLANK_BIT]), 32'h1);
    end
    $display("test 3 done");
    for (int i = 0; i < 64; i++) axw(12'h100 + 12'(4 * i), 32'h1000 + 32'(i));
    axw(OFS_ADDR, 32'h40);
    axw(OFS_COUNT, 32'd70);
    axr(OFS_COUNT);
    chk(rd, 32'h46); // register keeps what software wrote, the clamp acts on the job
    cmd({29'h0, CMD_WRITE});
    rdw(16'h0040);
    chk(rd, 32'h1000);
    rdw(16'h007f);
    chk(rd, 32'h103f);
    rdw(16'h0080);
    chk(rd, 32'h0000);
    $display("test 4 done");
    wr(16'h00be, 16'h0011, 16'h0022, 16'h0044, 7'd3);
    rdw(16'h00bf);
    chk(rd, 32'h0044);
    wr(16'h00bf, 16'h0100, 16'h0000, 16'h0000, 7'd1);
    rdw(16'h00bf);
    chk(rd, 32'h0144);
    $display("test 5 done");
    cmd({29'h0, CMD_DISABLE});
    axr(OFS_STATUS);
    chk(32'(rd[STAT_EN_BIT]), 32'h0);
    axw(OFS_ADDR, 32'h40);
    cmd({29'h0, CMD_ERASE});
    rdw(16'h0040);
    chk(rd, 32'h1000);
    $display("test 6 done");
    final_report;
  end
  // watchdog well beyond the expected run length
  initial begin
    #4000000;
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
